//--- verilog/tsf_pkg.sv
// Package of constants and types for the tagged sample FIFO
package tsf_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] TSF_OFS_WRITE_INDEX = 8'h04;
	localparam logic [7:0] TSF_OFS_READ_INDEX  = 8'h05;
	localparam logic [7:0] TSF_OFS_COUNT_HIGH  = 8'h06;
	localparam logic [7:0] TSF_OFS_COUNT_LOW   = 8'h07;
	localparam logic [7:0] TSF_OFS_READ_PORT   = 8'h08;
	localparam logic [7:0] TSF_OFS_THRESHOLD   = 8'h09;
	localparam logic [7:0] TSF_OFS_CONTROL     = 8'h0a;
	// Control register field positions
	localparam int TSF_CTL_RAW_BIT   = 7;
	localparam int TSF_CTL_FLUSH_BIT = 4;
	localparam int TSF_CTL_STAT_BIT  = 3;
	localparam int TSF_CTL_AFT_BIT   = 2;
	localparam int TSF_CTL_ROLL_BIT  = 1;
	// Command byte field position, high means read
	localparam int TSF_CMD_READ_BIT  = 7;
	// Reset values
	localparam logic [7:0] TSF_RST_THRESHOLD = 8'h00;
	localparam logic [7:0] TSF_RST_INDEX     = 8'h00;
	// Item layout
	localparam int TSF_ITEM_W   = 24;
	localparam int TSF_SAMPLE_W = 20;
	localparam int TSF_DEPTH    = 256;
	localparam logic [6:0] TSF_LOST_MAX = 7'h7f;
	// Tag codes
	localparam logic [3:0] TSF_TAG_DARK    = 4'ha;
	localparam logic [3:0] TSF_TAG_ALC     = 4'hb;
	localparam logic [3:0] TSF_TAG_EXP     = 4'hc;
	localparam logic [3:0] TSF_TAG_SPIKE   = 4'hd;
	localparam logic [3:0] TSF_TAG_INVALID = 4'he;
	localparam logic [3:0] TSF_MEAS_FIRST  = 4'h1;
	localparam logic [3:0] TSF_MEAS_LAST   = 4'h9;

	// One conversion result offered by the measurement sequencer
	typedef struct packed {
		logic [3:0]              meas;
		logic                    dark;
		logic                    ambient_cancel_overflow;
		logic                    exposure_overflow;
		logic                    spike_event;
		logic [TSF_SAMPLE_W-1:0] sample;
	} tsf_sample_type;

	// One stored item
	typedef struct packed {
		logic [3:0]              tag;
		logic [TSF_SAMPLE_W-1:0] sample;
	} tsf_item_type;

	// Serial transfer phases
	typedef enum logic [1:0] {TSF_PH_ADDR, TSF_PH_CMD, TSF_PH_DATA} tsf_phase_type;
endpackage

//--- verilog/tsf_top.sv
// Tagged sample FIFO with staging buffer and serial register port
// What this block does
// R1: Computed mode tags results 1 to 9
// R2: Raw mode tags dark samples with shared 0xA
// R3: Tag priority: spike, ambient, exposure, measurement
// R4: Raw mode disables spike replacement tags
// R5: Empty read returns invalid tag 0xE
// R6: Ambient overflow tags item 0xB in place
// R7: Exposure overflow tags item 0xC in place
// R8: Spike tag only when channel selects measurement
// R9: Write index advances per stored push, wraps
// R10: Read index advances per item read, wraps
// R11: Host may write read index to reread
// R12: Lost items counted, saturating at 0x7F
// R13: Lost counter clears when item popped
// R14: Host reads lost counter before draining
// R15: Nine-bit item count up and down
// R16: Three bytes at read port form one item
// R17: Host drains with burst reads
// R18: Only enabled measurements and raw-mode dark samples stored, in order
// R19: Both channels share tag, fixed order
// R20: Store holds 256 items of 24 bits
// R21: Tag in bits 23:20, sample below
// R22: Flush restarts store after configuration change
// R23: Invalid reads leave indices and counters alone
`timescale 1ns/1ps

// Staging FIFO between the sequencer and the main store
module tsf_stage_fifo
	import tsf_pkg::*;
#(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} tsf_stage_type;
	tsf_stage_type s_reg, s_next;
	logic do_in, do_out;

	// Handshakes from honest full and empty
	assign in_ready  = (s_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_reg.cnt != '0);
	assign out_data  = s_reg.mem[s_reg.rd];
	assign do_in     = in_valid && in_ready;
	assign do_out    = out_valid && out_ready;

	// Next state
	always_comb begin
		s_next = s_reg;
		if (do_in) begin
			s_next.mem[s_reg.wr] = in_data;
			s_next.wr = s_reg.wr + 1'b1;
		end
		if (do_out) begin
			s_next.rd = s_reg.rd + 1'b1;
		end
		s_next.cnt = s_reg.cnt + (AW+1)'(do_in) - (AW+1)'(do_out);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end
endmodule // tsf_stage_fifo

// Main store, tag selection and serial register slave
module tsf_top
	import tsf_pkg::*;
#(
	parameter int STAGE_DEPTH = 16
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           ce,
	input  wire logic           conv_valid,
	output logic                conv_ready,
	input  wire tsf_sample_type conv_sample,
	input  wire logic [8:0]     measurement_enable,
	input  wire logic [3:0]     spike_replace_select_ch1,
	input  wire logic [3:0]     spike_replace_select_ch2,
	input  wire logic           conv_channel,
	input  wire logic           sclk,
	input  wire logic           cs_n,
	input  wire logic           mosi,
	output logic                miso,
	output logic                miso_oe,
	output logic                almost_full
);
	typedef struct packed {
		logic [7:0]    write_index;
		logic [7:0]    read_index;
		logic [8:0]    count;
		logic [6:0]    lost_item_counter;
		logic [7:0]    threshold;
		logic          raw_collection_select;
		logic          status_clear_on_read;
		logic          afull_type;
		logic          rollover_enable;
		logic          sclk_s1, sclk_s2, sclk_s3;
		logic          cs_s1, cs_s2;
		logic          mosi_s1, mosi_s2;
		logic [2:0]    bit_cnt;
		tsf_phase_type phase;
		logic [7:0]    addr;
		logic          is_read;
		logic [7:0]    rx;
		logic [7:0]    tx;
		logic          load_pend;
		logic [1:0]    byte_sel;
		tsf_item_type  item;
		logic          item_ok;
	} tsf_state_type;

	tsf_state_type  s_reg, s_next;
	tsf_item_type   store [TSF_DEPTH];
	tsf_item_type   in_item, drain_item, fresh_item, cur_item;
	logic           in_store, spike_ok, in_take;
	logic           drain_valid, drain_ready, push_now, pop_now, full;
	logic           rise, fall, byte_done;
	logic [7:0]     rx_new;

	// Spike replacement allowed for this channel and measurement
	assign spike_ok = !s_reg.raw_collection_select && conv_sample.spike_event && //R4 R8
		(conv_sample.meas == (conv_channel ? spike_replace_select_ch2 : spike_replace_select_ch1));

	// Tag selection by priority
	always_comb begin
		in_item.sample = conv_sample.sample; //R21
		if (spike_ok) begin
			in_item.tag = TSF_TAG_SPIKE; //R3 R8
		end else if (conv_sample.ambient_cancel_overflow) begin
			in_item.tag = TSF_TAG_ALC; //R6
		end else if (conv_sample.exposure_overflow) begin
			in_item.tag = TSF_TAG_EXP; //R7
		end else if (conv_sample.dark && s_reg.raw_collection_select) begin
			in_item.tag = TSF_TAG_DARK; //R2
		end else begin
			in_item.tag = conv_sample.meas; //R1 R19
		end
	end

	// Only items of enabled measurements, or dark samples in raw mode, are kept
	always_comb begin
		in_store = 1'b0;
		if (conv_sample.dark) begin
			in_store = s_reg.raw_collection_select; //R2
		end else if (conv_sample.meas >= TSF_MEAS_FIRST && conv_sample.meas <= TSF_MEAS_LAST) begin
			in_store = measurement_enable[4'(conv_sample.meas - TSF_MEAS_FIRST)]; //R18
		end
	end

	// Items not kept are still accepted so the sequencer never hangs
	tsf_stage_fifo #(
		.WIDTH (TSF_ITEM_W),
		.DEPTH (STAGE_DEPTH)
	) u_stage (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (conv_valid && in_store),
		.in_ready  (in_take),
		.in_data   (in_item),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_item)
	);
	assign conv_ready = in_take;

	// Serial clock edges from the synchronised copies only
	assign rise      = s_reg.sclk_s2 && !s_reg.sclk_s3 && !s_reg.cs_s2;
	assign fall      = !s_reg.sclk_s2 && s_reg.sclk_s3 && !s_reg.cs_s2;
	assign byte_done = rise && (s_reg.bit_cnt == 3'd7);
	assign rx_new    = {s_reg.rx[6:0], s_reg.mosi_s2};

	// Pop after the third byte of a valid item has been shifted in
	assign pop_now = byte_done && s_reg.phase == TSF_PH_DATA && s_reg.is_read && //R16
		s_reg.addr == TSF_OFS_READ_PORT && s_reg.byte_sel == 2'd2 && s_reg.item_ok; //R23

	// The store stalls the staging FIFO while a pop completes
	assign full        = (s_reg.count == 9'(TSF_DEPTH));
	assign drain_ready = !pop_now;
	assign push_now    = drain_valid && drain_ready;

	// Item for the read port: invalid tag when empty
	assign fresh_item = (s_reg.count == '0) ? tsf_item_type'{TSF_TAG_INVALID, '0} //R5
		: store[s_reg.read_index];
	assign cur_item = (s_reg.byte_sel == 2'd0) ? fresh_item : s_reg.item;

	// Almost-full level against the threshold
	assign almost_full = (s_reg.count >= 9'(TSF_DEPTH) - {1'b0, s_reg.threshold});
	assign miso        = s_reg.tx[7];
	assign miso_oe     = !s_reg.cs_s2;

	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.sclk_s1 = sclk;
		s_next.sclk_s2 = s_reg.sclk_s1;
		s_next.sclk_s3 = s_reg.sclk_s2;
		s_next.cs_s1   = cs_n;
		s_next.cs_s2   = s_reg.cs_s1;
		s_next.mosi_s1 = mosi;
		s_next.mosi_s2 = s_reg.mosi_s1;
		// Store push and overflow handling
		if (push_now) begin
			if (!full || s_reg.rollover_enable) begin
				s_next.write_index = s_reg.write_index + 8'h01; //R9
			end
			if (full && s_reg.rollover_enable) begin
				s_next.read_index = s_reg.read_index + 8'h01;
			end
			if (!full) begin
				s_next.count = s_reg.count + 9'h001; //R15
			end else if (s_reg.lost_item_counter != TSF_LOST_MAX) begin
				s_next.lost_item_counter = s_reg.lost_item_counter + 7'h01; //R12
			end
		end
		// Complete item read by the host
		if (pop_now) begin
			s_next.read_index        = s_reg.read_index + 8'h01; //R10
			s_next.count             = s_reg.count - 9'h001; //R15
			s_next.lost_item_counter = '0; //R13
		end
		// Serial receive side
		if (rise) begin
			s_next.rx      = rx_new;
			s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
		end
		if (byte_done) begin
			unique case (s_reg.phase)
				TSF_PH_ADDR: begin
					s_next.addr  = rx_new;
					s_next.phase = TSF_PH_CMD;
				end
				TSF_PH_CMD: begin
					s_next.is_read   = rx_new[TSF_CMD_READ_BIT];
					s_next.phase     = TSF_PH_DATA;
					s_next.load_pend = rx_new[TSF_CMD_READ_BIT];
				end
				TSF_PH_DATA: begin
					if (s_reg.addr == TSF_OFS_READ_PORT) begin
						s_next.byte_sel = (s_reg.byte_sel == 2'd2) ? 2'd0 : s_reg.byte_sel + 2'd1;
					end else begin
						s_next.addr = s_reg.addr + 8'h01;
					end
					s_next.load_pend = s_reg.is_read;
					if (!s_reg.is_read) begin
						unique case (s_reg.addr)
							TSF_OFS_READ_INDEX: begin
								s_next.read_index = rx_new; //R11
								s_next.count = {1'b0, s_next.write_index - rx_new};
							end
							TSF_OFS_THRESHOLD: begin
								s_next.threshold = rx_new;
							end
							TSF_OFS_CONTROL: begin
								s_next.raw_collection_select = rx_new[TSF_CTL_RAW_BIT];
								s_next.status_clear_on_read  = rx_new[TSF_CTL_STAT_BIT];
								s_next.afull_type            = rx_new[TSF_CTL_AFT_BIT];
								s_next.rollover_enable       = rx_new[TSF_CTL_ROLL_BIT];
								if (rx_new[TSF_CTL_FLUSH_BIT]) begin
									s_next.write_index       = TSF_RST_INDEX; //R22
									s_next.read_index        = TSF_RST_INDEX;
									s_next.count             = '0;
									s_next.lost_item_counter = '0;
								end
							end
							default: begin
							end
						endcase
					end
				end
				default: begin
					s_next.phase = TSF_PH_ADDR;
				end
			endcase
		end
		// Serial transmit side: load a byte or shift out the next bit
		if (fall) begin
			if (s_reg.load_pend) begin
				s_next.load_pend = 1'b0;
				unique case (s_reg.addr)
					TSF_OFS_WRITE_INDEX: s_next.tx = s_reg.write_index;
					TSF_OFS_READ_INDEX:  s_next.tx = s_reg.read_index;
					TSF_OFS_COUNT_HIGH:  s_next.tx = {s_reg.count[8], s_reg.lost_item_counter}; //R15
					TSF_OFS_COUNT_LOW:   s_next.tx = s_reg.count[7:0];
					TSF_OFS_READ_PORT: begin
						s_next.tx = (s_reg.byte_sel == 2'd0) ? cur_item[23:16] //R16
							: (s_reg.byte_sel == 2'd1) ? cur_item[15:8] : cur_item[7:0];
						if (s_reg.byte_sel == 2'd0) begin
							s_next.item    = fresh_item;
							s_next.item_ok = (s_reg.count != '0); //R23
						end
					end
					TSF_OFS_THRESHOLD:   s_next.tx = s_reg.threshold;
					TSF_OFS_CONTROL: begin
						s_next.tx = {s_reg.raw_collection_select, 3'b000, s_reg.status_clear_on_read,
							s_reg.afull_type, s_reg.rollover_enable, 1'b0};
					end
					default:             s_next.tx = 8'h00;
				endcase
			end else begin
				s_next.tx = {s_reg.tx[6:0], 1'b0};
			end
		end
		// Chip select high ends the transfer
		if (s_reg.cs_s2) begin
			s_next.phase     = TSF_PH_ADDR;
			s_next.bit_cnt   = '0;
			s_next.byte_sel  = '0;
			s_next.load_pend = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg           <= '0;
			s_reg.threshold <= TSF_RST_THRESHOLD;
			s_reg.sclk_s1   <= 1'b0;
			s_reg.cs_s1     <= 1'b1;
			s_reg.cs_s2     <= 1'b1;
			s_reg.phase     <= TSF_PH_ADDR;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Item store, written on push at the write index
	always_ff @(posedge clk) begin
		if (ce && push_now && (!full || s_reg.rollover_enable)) begin
			store[s_reg.write_index] <= drain_item; //R20
		end
	end

	AST_WR_WRAP: assert property (@(posedge clk) disable iff (!rst_n) //R9
		ce && push_now && !full && s_reg.write_index == 8'hff |=> s_reg.write_index == 8'h00)
		else $error("write index did not wrap");
	AST_RD_ADV: assert property (@(posedge clk) disable iff (!rst_n) //R10
		ce && pop_now |=> s_reg.read_index == $past(s_reg.read_index) + 8'h01)
		else $error("read index did not advance on pop");
	AST_LOST_CLR: assert property (@(posedge clk) disable iff (!rst_n) //R13
		ce && pop_now |=> s_reg.lost_item_counter == 7'h00)
		else $error("lost counter not cleared on pop");
	AST_LOST_SAT: assert property (@(posedge clk) disable iff (!rst_n) //R12
		ce && !pop_now && !byte_done && s_reg.lost_item_counter == TSF_LOST_MAX
		|=> s_reg.lost_item_counter == TSF_LOST_MAX)
		else $error("lost counter left saturation");
	AST_COUNT_UP: assert property (@(posedge clk) disable iff (!rst_n) //R15
		ce && push_now && !full && !byte_done |=> s_reg.count == $past(s_reg.count) + 9'h001)
		else $error("item count did not increment");
	AST_INVALID: assert property (@(posedge clk) disable iff (!rst_n) //R5
		ce && fall && s_reg.load_pend && s_reg.addr == TSF_OFS_READ_PORT && s_reg.byte_sel == 2'd0
		&& s_reg.count == '0 |=> s_reg.item.tag == TSF_TAG_INVALID && !s_reg.item_ok)
		else $error("empty read did not give invalid tag");
	AST_NO_SPIKE_RAW: assert property (@(posedge clk) disable iff (!rst_n) //R4
		s_reg.raw_collection_select |-> in_item.tag != TSF_TAG_SPIKE)
		else $error("spike tag produced in raw mode");
	AST_PRIORITY: assert property (@(posedge clk) disable iff (!rst_n) //R3
		!spike_ok && conv_sample.ambient_cancel_overflow |-> in_item.tag == TSF_TAG_ALC)
		else $error("ambient overflow tag lost priority");
	AST_INVALID_HOLD: assert property (@(posedge clk) disable iff (!rst_n) //R23
		ce && byte_done && s_reg.is_read && s_reg.phase == TSF_PH_DATA && !s_reg.item_ok
		&& s_reg.addr == TSF_OFS_READ_PORT && s_reg.byte_sel == 2'd2 && !push_now
		|=> s_reg.read_index == $past(s_reg.read_index) && s_reg.count == $past(s_reg.count)
		&& s_reg.lost_item_counter == $past(s_reg.lost_item_counter))
		else $error("invalid item changed indices or counters");
endmodule // tsf_top

//--- tb/tsf_host_model.sv
// Host model driving the serial register port of the tagged sample FIFO
`timescale 1ns/1ps

module tsf_host_model (
	input  wire logic        clk,
	output logic             sclk,
	output logic             cs_n,
	output logic             mosi,
	input  wire logic        miso,
	input  wire logic        miso_oe,
	output logic             rd_done,
	output logic      [23:0] rd_data
);
	// Idle levels: clock stands still low, deselected
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		rd_done = 1'b0;
		rd_data = '0;
	end

	// One byte, MSB first; sample miso on rise, change mosi after fall
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			rx[i] = miso_oe ? miso : 1'b1; // Released line reads as pulled up
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
	endtask

	// Address, command, then n data bytes as one burst
	task automatic xfer(input logic [7:0] addr, input logic rd, input int n,
		input logic [23:0] wdat, output logic [23:0] rdat);
		logic [7:0] b;
		rdat = '0;
		@(posedge clk) cs_n <= 1'b0;
		repeat (3) @(posedge clk);
		shift(addr, b);
		shift({rd, 7'h00}, b);
		for (int i = 0; i < n; i++) begin
			shift(wdat[23-8*i -: 8], b);
			rdat = {rdat[15:0], b};
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (4) @(posedge clk);
		if (rd) begin
			rd_data <= rdat;
			rd_done <= 1'b1;
			@(posedge clk) rd_done <= 1'b0;
		end
	endtask
endmodule // tsf_host_model

//--- tb/tsf_top_bench.sv
// Self-checking bench for the tagged sample FIFO
`timescale 1ns/1ps

module tsf_top_bench;
	import tsf_pkg::*;
	logic           clk;
	logic           rst_n;
	logic           conv_valid;
	logic           conv_ready;
	tsf_sample_type conv_sample;
	logic [8:0]     measurement_enable;
	logic [3:0]     sel1;
	logic [3:0]     sel2;
	logic           conv_channel;
	logic           sclk;
	logic           cs_n;
	logic           mosi;
	logic           miso;
	logic           miso_oe;
	logic           almost_full;
	logic           rd_done;
	logic [23:0]    rd_data;
	logic [23:0]    last;
	logic [31:0]    seed;
	logic [23:0]    exp_q[$];
	logic [23:0]    item_q[$];
	int             bad_count = 0;
	int             checks = 0;

	tsf_top u_tsf_top (.clk(clk), .rst_n(rst_n), .ce(1'b1), .conv_valid(conv_valid),
		.conv_ready(conv_ready), .conv_sample(conv_sample),
		.measurement_enable(measurement_enable), .spike_replace_select_ch1(sel1),
		.spike_replace_select_ch2(sel2), .conv_channel(conv_channel), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.almost_full(almost_full));

	tsf_host_model u_tsf_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .rd_done(rd_done), .rd_data(rd_data));

	// Clock at 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic compare(input logic [23:0] seen, input logic [23:0] expv);
		checks++;
		if (seen !== expv) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	task automatic print_verdict();
		if (bad_count == 0 && checks > 0 && exp_q.size() == 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Host read; expected value noted first
	task automatic rd(input logic [7:0] a, input int n, input logic [23:0] e);
		logic [23:0] r;
		exp_q.push_back(e);
		u_tsf_host_model.xfer(a, 1'b1, n, 24'h00_0000, r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [23:0] r;
		u_tsf_host_model.xfer(a, 1'b0, 1, {d, 16'h0000}, r);
	endtask

	// Offer one sample; flags are dark, ambient, exposure, spike; tag 0 means dropped
	task automatic push(input logic [3:0] m, input logic [3:0] f, input logic ch,
		input logic [3:0] t);
		seed = lfsr(seed);
		if (t != 4'h0)
			item_q.push_back({t, seed[19:0]});
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_sample <= {m, f, seed[19:0]};
		conv_channel <= ch;
		do @(negedge clk); while (conv_ready !== 1'b1);
		@(posedge clk) conv_valid <= 1'b0;
	endtask

	// Result monitor takes the oldest note per read
	always @(posedge clk) begin
		if (rd_done === 1'b1) begin
			if (exp_q.size() == 0)
				compare(rd_data, ~rd_data);
			else
				compare(rd_data, exp_q.pop_front());
		end
	end

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		conv_valid = 1'b0;
		conv_sample = '0;
		conv_channel = 1'b0;
		measurement_enable = 9'h1ef;
		sel1 = 4'h3;
		sel2 = 4'h4;
		seed = 32'hf299;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(TSF_OFS_WRITE_INDEX, 1, 24'h00_0000);
		rd(8'h20, 1, 24'h00_0000);
		rd(TSF_OFS_READ_PORT, 3, 24'he0_0000);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_0000);
		compare(24'(almost_full), 24'h00_0000);
		for (int m = 1; m <= 9; m++)
			for (int c = 0; c < 2; c++)
				push(m[3:0], 4'h0, c[0], (m == 5) ? 4'h0 : m[3:0]);
		push(4'h3, 4'h1, 1'b0, TSF_TAG_SPIKE);
		push(4'h3, 4'h1, 1'b1, 4'h3);
		push(4'h4, 4'h7, 1'b1, TSF_TAG_SPIKE);
		push(4'h2, 4'h6, 1'b0, TSF_TAG_ALC);
		push(4'h2, 4'h2, 1'b0, TSF_TAG_EXP);
		push(4'h1, 4'h8, 1'b0, 4'h0);
		wr(TSF_OFS_CONTROL, 8'h80);
		push(4'h6, 4'h8, 1'b0, TSF_TAG_DARK);
		push(4'h3, 4'h1, 1'b0, 4'h3);
		repeat (10) @(posedge clk);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_0017);
		rd(TSF_OFS_WRITE_INDEX, 1, 24'h00_0017);
		rd(TSF_OFS_COUNT_HIGH, 1, 24'h00_0000);
		last = item_q[$];
		while (item_q.size() > 0)
			rd(TSF_OFS_READ_PORT, 3, item_q.pop_front());
		rd(TSF_OFS_READ_INDEX, 1, 24'h00_0017);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_0000);
		wr(TSF_OFS_READ_INDEX, 8'h16);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_0001);
		rd(TSF_OFS_READ_PORT, 3, last);
		rd(TSF_OFS_READ_PORT, 3, 24'he0_0000);
		rd(TSF_OFS_READ_INDEX, 1, 24'h00_0017);
		wr(TSF_OFS_CONTROL, 8'h10);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_0000);
		for (int i = 0; i < 386; i++)
			push(4'h1, 4'h0, 1'b0, (i < 256) ? 4'h1 : 4'h0);
		repeat (10) @(posedge clk);
		rd(TSF_OFS_COUNT_HIGH, 1, 24'h00_00ff);
		rd(TSF_OFS_WRITE_INDEX, 1, 24'h00_0000);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_0000);
		rd(TSF_OFS_READ_PORT, 3, item_q.pop_front());
		rd(TSF_OFS_COUNT_HIGH, 1, 24'h00_0000);
		rd(TSF_OFS_COUNT_LOW, 1, 24'h00_00ff);
		rd(TSF_OFS_READ_INDEX, 1, 24'h00_0001);
		wr(TSF_OFS_READ_INDEX, 8'hff);
		rd(TSF_OFS_READ_PORT, 3, item_q[254]);
		rd(TSF_OFS_READ_INDEX, 1, 24'h00_0000);
		// Threshold, stored control bits and rollover of the oldest item
		wr(TSF_OFS_THRESHOLD, 8'h10);
		rd(TSF_OFS_THRESHOLD, 1, 24'h00_0010);
		wr(TSF_OFS_CONTROL, 8'h0e);
		rd(TSF_OFS_CONTROL, 1, 24'h00_000e);
		item_q.delete();
		for (int i = 0; i < 258; i++)
			push(4'h2, 4'h0, i[0], 4'h2);
		repeat (10) @(posedge clk);
		compare(24'(almost_full), 24'h00_0001);
		rd(TSF_OFS_COUNT_HIGH, 1, 24'h00_0082);
		rd(TSF_OFS_READ_INDEX, 1, 24'h00_0002);
		rd(TSF_OFS_WRITE_INDEX, 1, 24'h00_0002);
		rd(TSF_OFS_READ_PORT, 3, item_q[2]);
		rd(TSF_OFS_COUNT_HIGH, 1, 24'h00_0000);
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule // tsf_top_bench
